/* sleep_port_clock_gating.sv */
// What this block does
// [RQ1] eight read/write enable bits, bit 7 port H down to bit 0 port A
// [RQ2] an enable bit at one supplies that port's clock
// [RQ3] an enable bit at zero stops that port's clock, port held disabled
// [RQ4] accesses to an unclocked port are answered with a bus fault
// [RQ5] reset clears all enable registers to zero
// [RQ6] sleep register governs sleep; run and deep-sleep registers share layout
// [RQ7] sleep enables apply only when auto clock gating select is set
// [RQ8] bits 31 to 8 read as zero and ignore writes
// [RQ9] sleep register decoded at offset 118 from the system-control base
// [RQ10] entering sleep with auto gating uses sleep bits; leaving restores run bits
//
// Register access over Avalon-MM was decided locally.
`include "port_clock_defs.svh"
`default_nettype none

module sleep_port_clock_gating #(
  parameter int NUM_PORTS = `NUM_PORTS
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [`ADDR_W-1:0]     avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic      [1:0]             avs_response,
  output logic                        avs_waitrequest,
  input  wire logic                   sleep_req,
  input  wire logic                   deep_sleep_req,
  input  wire logic                   port_access,
  input  wire logic [`PORT_SEL_W-1:0] port_select,
  output logic                        port_bus_fault,
  output logic      [NUM_PORTS-1:0]   port_clk,
  output logic      [NUM_PORTS-1:0]   port_clock_on,
  output logic                        irq
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic [NUM_PORTS-1:0]        run_pce;
    logic [NUM_PORTS-1:0]        sleep_pce;
    logic [NUM_PORTS-1:0]        deep_pce;
    logic                        auto_clock_gating_select;
    port_clock_pkg::pwr_mode_e   mode;
    port_clock_pkg::bus_state_e  bus;
    logic [31:0]                 rdata;
    logic [1:0]                  resp;
    logic                        waitreq;
    logic [`IRQ_W-1:0]           irq_status;
    logic [`IRQ_W-1:0]           irq_mask;
    logic [`PORT_SEL_W-1:0]      fault_port;
    logic                        fault;
    logic                        irq;
  } ctl_s;

  ctl_s st_ff;
  ctl_s nxt_st;

  logic [NUM_PORTS-1:0] active_en;
  logic [NUM_PORTS-1:0] gate_on;
  logic [NUM_PORTS-1:0] gate_fault;
  logic [NUM_PORTS-1:0] sel_access;

  // ***********************************************************
  // enable source selection by power mode
  // ***********************************************************
  always_comb begin
    active_en = st_ff.run_pce;
    case (st_ff.mode)
      port_clock_pkg::PWR_RUN: begin
        active_en = st_ff.run_pce; // RQ10
      end
      port_clock_pkg::PWR_SLEEP: begin
        active_en = st_ff.auto_clock_gating_select ? st_ff.sleep_pce : st_ff.run_pce; // RQ6 RQ7 RQ10
      end
      port_clock_pkg::PWR_DEEP: begin
        active_en = st_ff.auto_clock_gating_select ? st_ff.deep_pce : st_ff.run_pce; // RQ6 RQ7
      end
      default: begin
        active_en = st_ff.run_pce;
      end
    endcase
  end

  // ***********************************************************
  // per-port gates
  // ***********************************************************
  always_comb begin
    sel_access = '0;
    sel_access[port_select] = port_access;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      port_clock_gate u_gate (
        .clk       (clk),
        .nrst      (nrst),
        .enable    (active_en[gi]), // RQ2 RQ3
        .access    (sel_access[gi]),
        .gated_clk (port_clk[gi]),
        .clock_on  (gate_on[gi]),
        .fault     (gate_fault[gi])
      );
    end
  endgenerate

  // ***********************************************************
  // register bus, mode tracking, interrupts
  // ***********************************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [31:0] wv;
  logic [`IRQ_W-1:0] ev;
  logic [`IRQ_W-1:0] w1c;

  always_comb begin
    nxt_st = st_ff;
    wv     = '0;
    ev     = '0;
    w1c    = '0;

    // power mode follows the requests
    if (deep_sleep_req) begin
      nxt_st.mode = port_clock_pkg::PWR_DEEP;
    end else if (sleep_req) begin
      nxt_st.mode = port_clock_pkg::PWR_SLEEP; // RQ10
    end else begin
      nxt_st.mode = port_clock_pkg::PWR_RUN; // RQ10
    end
    if (nxt_st.mode != st_ff.mode) begin
      ev[`IRQ_MODE_BIT] = 1'b1;
    end

    // access to a gated port
    nxt_st.fault = |gate_fault; // RQ4
    if (|gate_fault) begin
      ev[`IRQ_FAULT_BIT] = 1'b1;
      nxt_st.fault_port  = port_select;
    end

    case (st_ff.bus)
      port_clock_pkg::BUS_IDLE: begin
        nxt_st.waitreq = 1'b1;
        if (avs_read || avs_write) begin
          nxt_st.bus     = port_clock_pkg::BUS_ANSWER;
          nxt_st.waitreq = 1'b0;
          nxt_st.resp    = 2'h0;
          nxt_st.rdata   = `READ_ZERO;
          case (avs_address)
            `OFS_RUN_CFG: begin
              nxt_st.rdata[`ACG_BIT] = st_ff.auto_clock_gating_select;
              wv = merge({4'h0, st_ff.auto_clock_gating_select, 27'h0}, avs_writedata, avs_byteenable);
              if (avs_write) nxt_st.auto_clock_gating_select = wv[`ACG_BIT];
            end
            `OFS_RUN_PCE: begin
              nxt_st.rdata[NUM_PORTS-1:0] = st_ff.run_pce;
              wv = merge({24'h0, st_ff.run_pce}, avs_writedata, avs_byteenable);
              if (avs_write) nxt_st.run_pce = wv[NUM_PORTS-1:0];
            end
            `OFS_SLEEP_PCE: begin // RQ9
              nxt_st.rdata[NUM_PORTS-1:0] = st_ff.sleep_pce; // RQ1 RQ8
              wv = merge({24'h0, st_ff.sleep_pce}, avs_writedata, avs_byteenable);
              if (avs_write) nxt_st.sleep_pce = wv[NUM_PORTS-1:0]; // RQ1 RQ8
            end
            `OFS_DEEP_PCE: begin
              nxt_st.rdata[NUM_PORTS-1:0] = st_ff.deep_pce; // RQ6
              wv = merge({24'h0, st_ff.deep_pce}, avs_writedata, avs_byteenable);
              if (avs_write) nxt_st.deep_pce = wv[NUM_PORTS-1:0];
            end
            `OFS_MODE_CTRL: begin
              nxt_st.rdata[`MODE_SLEEP_BIT] = (st_ff.mode == port_clock_pkg::PWR_SLEEP);
              nxt_st.rdata[`MODE_DEEP_BIT]  = (st_ff.mode == port_clock_pkg::PWR_DEEP);
            end
            `OFS_IRQ_STATUS: begin
              nxt_st.rdata[`IRQ_W-1:0] = st_ff.irq_status;
              if (avs_write && avs_byteenable[0]) w1c = avs_writedata[`IRQ_W-1:0];
            end
            `OFS_IRQ_MASK: begin
              nxt_st.rdata[`IRQ_W-1:0] = st_ff.irq_mask;
              if (avs_write && avs_byteenable[0]) begin
                nxt_st.irq_mask = avs_writedata[`IRQ_W-1:0];
              end
            end
            `OFS_FAULT_PORT: begin
              nxt_st.rdata[`PORT_SEL_W-1:0] = st_ff.fault_port;
              nxt_st.rdata[NUM_PORTS+7:8]   = gate_on;
            end
            default: begin
              nxt_st.resp = 2'h2;
            end
          endcase
        end
      end
      port_clock_pkg::BUS_ANSWER: begin
        nxt_st.bus     = port_clock_pkg::BUS_IDLE;
        nxt_st.waitreq = 1'b1;
        nxt_st.resp    = 2'h0;
      end
      default: begin
        nxt_st.bus     = port_clock_pkg::BUS_IDLE;
        nxt_st.waitreq = 1'b1;
      end
    endcase

    // set wins over clear
    nxt_st.irq_status = (st_ff.irq_status & ~w1c) | ev;
    nxt_st.irq        = |(nxt_st.irq_status & nxt_st.irq_mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff            <= '0; // RQ5
      st_ff.run_pce    <= `PCE_RESET; // RQ5
      st_ff.sleep_pce  <= `PCE_RESET; // RQ5
      st_ff.deep_pce   <= `PCE_RESET; // RQ5
      st_ff.mode       <= port_clock_pkg::PWR_RUN;
      st_ff.bus        <= port_clock_pkg::BUS_IDLE;
      st_ff.waitreq    <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata    = st_ff.rdata;
  assign avs_response    = st_ff.resp;
  assign avs_waitrequest = st_ff.waitreq;
  assign port_bus_fault  = st_ff.fault;
  assign port_clock_on   = gate_on;
  assign irq             = st_ff.irq;

endmodule : sleep_port_clock_gating

`default_nettype wire

/* port_clock_defs.svh */
`ifndef PORT_CLOCK_DEFS_SVH
`define PORT_CLOCK_DEFS_SVH

// ***********************************************************
// register map (byte addresses relative to system-control base)
// ***********************************************************
`define SYSCTL_BASE            32'h400FE000
`define OFS_RUN_CFG            12'h060
`define OFS_RUN_PCE            12'h108
`define OFS_SLEEP_PCE          12'h118
`define OFS_DEEP_PCE           12'h128
`define OFS_MODE_CTRL          12'h200
`define OFS_IRQ_STATUS         12'h204
`define OFS_IRQ_MASK           12'h208
`define OFS_FAULT_PORT         12'h20C

// ***********************************************************
// fields and reset values
// ***********************************************************
`define NUM_PORTS              8
`define PCE_RESET              8'h00
`define ACG_BIT                27
`define MODE_SLEEP_BIT         0
`define MODE_DEEP_BIT          1
`define IRQ_FAULT_BIT          0
`define IRQ_MODE_BIT           1
`define IRQ_W                  2
`define READ_ZERO              32'h00000000
`define ADDR_W                 12
`define PORT_SEL_W             3

`endif

/* port_clock_pkg.sv */
`default_nettype none

package port_clock_pkg;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SLEEP,
    PWR_DEEP
  } pwr_mode_e;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_e;

endpackage : port_clock_pkg

`default_nettype wire

/* port_clock_gate.sv */
`default_nettype none

// ***********************************************************
// one port: glitch-free clock gate and access fault check
// ***********************************************************
module port_clock_gate (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic access,
  output logic      gated_clk,
  output logic      clock_on,
  output logic      fault
);

  typedef struct packed {
    logic latch_en;
    logic on;
  } gate_s;

  gate_s st_ff;
  gate_s nxt_st;

  // enable latched while the clock is low, as in a standard icg cell
  logic en_lat;

  always_latch begin
    if (!clk) begin
      en_lat = st_ff.latch_en;
    end
  end

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.latch_en = enable;
    nxt_st.on       = enable;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign gated_clk = clk & en_lat;
  assign clock_on  = st_ff.on;
  assign fault     = access & ~st_ff.on;

endmodule : port_clock_gate

`default_nettype wire

/* sleep_port_clock_gating_checker.sv */
`default_nettype none
// ****************************************
// bus answer and port gating checks
// ****************************************
module sleep_port_clock_gating_checker #(
  parameter int NUM_PORTS = 8
) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic [11:0]          avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic [1:0]           avs_response,
  input wire logic                 avs_waitrequest,
  input wire logic                 sleep_req,
  input wire logic                 deep_sleep_req,
  input wire logic                 port_access,
  input wire logic [2:0]           port_select,
  input wire logic                 port_bus_fault,
  input wire logic [NUM_PORTS-1:0] port_clock_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  AST_ONE_CYCLE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  AST_RO_ZERO: assert property (
    avs_read && !avs_waitrequest && avs_address == 12'h118 |-> avs_readdata[31:8] == 24'h0)
    else $error("upper enable bits not zero");
  AST_SLVERR: assert property (avs_read && !avs_waitrequest && avs_address == 12'h300
    |-> avs_response == 2'h2 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  AST_FAULT: assert property (port_access && !port_clock_on[port_select] |=> port_bus_fault)
    else $error("no fault on unclocked port");
  AST_NO_FAULT: assert property (!port_access |=> !port_bus_fault)
    else $error("fault without access");
  AST_RESET_CLEAR: assert property ($rose(nrst) |-> port_clock_on == {NUM_PORTS{1'b0}})
    else $error("enables not clear after reset");
  AST_HOLD: assert property (
    !$past(avs_write) && $past(sleep_req) == $past(sleep_req, 2)
    && $past(deep_sleep_req) == $past(deep_sleep_req, 2) |=> $stable(port_clock_on))
    else $error("enables changed without cause");
endmodule : sleep_port_clock_gating_checker

bind sleep_port_clock_gating sleep_port_clock_gating_checker #(.NUM_PORTS(NUM_PORTS)) chk_i (
  .clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_response,
  .avs_waitrequest, .sleep_req, .deep_sleep_req, .port_access, .port_select,
  .port_bus_fault, .port_clock_on);
`default_nettype wire

/* port_model.sv */
`default_nettype none
// ****************************************
// far-side ports: note clock edges per port
// ****************************************
module port_model (
  input  wire logic [7:0] port_clk,
  input  wire logic       clr,
  output var  logic [7:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  for (genvar i = 0; i < 8; i++) begin : g_port
    always @(posedge port_clk[i] or posedge clr) begin
      if (clr) seen[i] <= 1'b0;
      else seen[i] <= 1'b1;
    end
  end
endmodule : port_model
`default_nettype wire

/* sleep_port_clock_gating_test.sv */
`default_nettype none
// ****************************************
// bench
// ****************************************
module sleep_port_clock_gating_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic        sleep_req, deep_sleep_req, port_access, port_bus_fault, irq, clr;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, d;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response, rsp;
  logic [2:0]  port_select;
  logic [7:0]  port_clk, port_clock_on, seen, ex;
  logic [7:0]  pce [3];
  int          fail_count, checked;

  sleep_port_clock_gating dut (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_response, .avs_waitrequest,
    .sleep_req, .deep_sleep_req, .port_access, .port_select, .port_bus_fault,
    .port_clk, .port_clock_on, .irq);
  port_model far (.port_clk, .clr, .seen);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done;
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v,
                     input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= w;
    avs_read       <= !w;
    avs_writedata  <= v;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    rsp = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : wt

  task automatic probe;
    int i;
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    wt(4);
    chk(seen, ex);
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      port_access <= 1'b1;
      port_select <= 3'(i);
      @(posedge clk) port_access <= 1'b0;
      #1;
      chk(port_bus_fault, !ex[i]);
    end
  endtask : probe

  initial begin
    #500000;
    fail_count++;
    test_done;
  end

  initial begin
    int k, m, auto_clock_gating_select;
    {nrst, avs_read, avs_write, sleep_req, deep_sleep_req, port_access, clr} = '0;
    {avs_address, avs_writedata, avs_byteenable, port_select} = '0;
    fail_count = 0;
    checked = 0;
    void'($urandom(32'h54EE));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (k = 0; k < 3; k++) begin
      bus(1'b0, 12'(12'h108 + 16 * k), 32'h0, 4'hF);
      chk(q, 32'h0);
      d = $urandom;
      bus(1'b1, 12'(12'h108 + 16 * k), d, 4'hE);
      bus(1'b0, 12'(12'h108 + 16 * k), 32'h0, 4'hF);
      chk(q, 32'h0);
      bus(1'b1, 12'(12'h108 + 16 * k), d, 4'hF);
      pce[k] = d[7:0];
      bus(1'b0, 12'(12'h108 + 16 * k), 32'h0, 4'hF);
      chk(q, {24'h0, pce[k]});
    end
    bus(1'b0, 12'h300, 32'h0, 4'hF);
    chk(q, 32'h0);
    chk(rsp, 2'h2);
    for (auto_clock_gating_select = 0; auto_clock_gating_select < 2; auto_clock_gating_select++) begin
      bus(1'b1, 12'h060, 32'(auto_clock_gating_select) << 27, 4'hF);
      for (m = 0; m < 3; m++) begin
        @(posedge clk);
        sleep_req <= (m == 1);
        deep_sleep_req <= (m == 2);
        wt(3);
        ex = (auto_clock_gating_select == 1) ? pce[m] : pce[0];
        chk(port_clock_on, ex);
        probe;
      end
    end
    @(posedge clk);
    sleep_req      <= 1'b0;
    deep_sleep_req <= 1'b0;
    bus(1'b1, 12'h108, 32'h0, 4'hF);
    bus(1'b1, 12'h208, 32'h1, 4'hF);
    bus(1'b1, 12'h204, 32'h3, 4'hF);
    wt(2);
    chk(irq, 1'b0);
    ex = 8'h00;
    probe;
    wt(2);
    chk(irq, 1'b1);
    bus(1'b1, 12'h204, 32'h1, 4'hF);
    wt(2);
    chk(irq, 1'b0);
    bus(1'b1, 12'h208, 32'h0, 4'hF);
    probe;
    wt(2);
    chk(irq, 1'b0);
    bus(1'b0, 12'h204, 32'h0, 4'hF);
    chk(q[0], 1'b1);
    test_done;
  end
endmodule : sleep_port_clock_gating_test
`default_nettype wire
